// File: rav_pkg.sv
// package for the alarm value window: offsets, field layout, resets, types
//
// Operation
// - pointer 10/01/00 selects alarm view
// - month/day, weekday/hours writes need write enable
// - bit 12 holds month tens digit
// - bits 11:8 hold month ones digit
// - bits 5:4 hold day tens digit
// - bits 3:0 hold day ones digit
// - bits 10:8 hold weekday value
// - bits 5:4 hold hour tens digit
// - bits 3:0 hold hour ones digit
// - bits 14:12 hold minute tens digit
// - bits 11:8 hold minute ones digit
// - bits 6:4 hold second tens digit
// - bits 3:0 hold second ones digit
// - unused bits read zero, ignore writes
// - clock window, own pointer, same layout
package rav_pkg;
   // ************************************************
   // register byte offsets
   // ************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00; // write enable and both pointers
   localparam logic [7:0] OFS_ALARM = 8'h04; // alarm value window
   localparam logic [7:0] OFS_CLOCK = 8'h08; // clock value window, read only
   localparam logic [7:0] OFS_STATUS = 8'h0C; // sticky events, write one to clear
   localparam logic [7:0] OFS_MASK = 8'h10; // interrupt mask
   // ************************************************
   // control register fields
   // ************************************************
   localparam int CTRL_WREN_POS = 0; // clock write enable
   localparam int CTRL_APTR_POS = 8; // alarm view pointer, 2 bits
   localparam int CTRL_CPTR_POS = 12; // clock view pointer, 2 bits
   // ************************************************
   // status and mask bits
   // ************************************************
   localparam int EV_MATCH_POS = 0; // alarm matched running clock
   localparam int EV_LOCKED_POS = 1; // write refused, enable was low
   localparam int EV_COUNT = 2;
   // ************************************************
   // view pointer codes and window field positions
   // ************************************************
   localparam logic [1:0] VIEW_MONTH_DAY = 2'h2;
   localparam logic [1:0] VIEW_WEEKDAY_VALUE_HOUR = 2'h1;
   localparam logic [1:0] VIEW_MIN_SEC = 2'h0;
   localparam int HI_TEN_POS = 12; // month tens, minute tens
   localparam int HI_ONE_POS = 8; // month, weekday, minute ones
   localparam int LO_TEN_POS = 4; // day, hour, second tens
   localparam int LO_ONE_POS = 0; // day, hour, second ones
   // ************************************************
   // reset values
   // ************************************************
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [EV_COUNT-1:0] EV_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // one calendar time, either alarm setting or running clock
   typedef struct packed {
      logic [0:0] month_tens_digit;
      logic [3:0] month_ones_digit;
      logic [1:0] day_tens_digit;
      logic [3:0] day_ones_digit;
      logic [2:0] weekday_value;
      logic [1:0] hour_tens_digit;
      logic [3:0] hour_ones_digit;
      logic [2:0] minute_tens_digit;
      logic [3:0] minute_ones_digit;
      logic [2:0] second_tens_digit;
      logic [3:0] second_ones_digit;
   } rav_time_type;
endpackage : rav_pkg

// File: rav_alarm_window.sv
// alarm value window with clock window, AXI4-Lite slave and alarm interrupt
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module rav_alarm_window
   import rav_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire rav_time_type i_clock_time, // running calendar time
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic o_irq
);
   // ************************************************
   // state
   // ************************************************
   logic [31:0] ctrl; // enable and pointers
   logic [EV_COUNT-1:0] ev_status; // sticky events
   logic [EV_COUNT-1:0] ev_mask; // interrupt mask
   rav_time_type alarm; // stored alarm, no reset
   logic [2:0] view_written; // one bit per view once written
   logic [7:0] aw_addr; // held write address
   logic aw_held; // write address taken
   logic [31:0] w_data; // held write data
   logic [3:0] w_strb; // held byte strobes
   logic w_held; // write data taken
   logic match_d; // previous match level, for edge
   logic clock_write_enable; // from control
   logic [1:0] alarm_view_pointer; // selects alarm view
   logic [1:0] clock_view_pointer; // selects clock view
   logic commit; // write performed this cycle
   logic [31:0] wmask; // strobes spread to bits
   logic [15:0] alarm_wr; // masked new window value
   logic [15:0] alarm_value_window; // alarm view as read
   logic [15:0] clock_value_window; // clock view as read
   logic alarm_locked; // write hits a locked view
   logic match_now; // alarm equals running time
   logic [31:0] next_rdata; // read mux
   logic next_rerr; // unmapped read
   logic [EV_COUNT-1:0] ev_clr; // status bits software clears this cycle
   logic [EV_COUNT-1:0] ev_set; // status bits hardware raises this cycle

   assign clock_write_enable = ctrl[CTRL_WREN_POS];
   assign alarm_view_pointer = ctrl[CTRL_APTR_POS +: 2];
   assign clock_view_pointer = ctrl[CTRL_CPTR_POS +: 2];
   assign commit = aw_held && w_held && !s_axi_bvalid;

   // ************************************************
   // view formatting
   // ************************************************
   // lay one time out as the view the pointer picks; unused bits stay zero
   function automatic logic [15:0] view_of(input rav_time_type t, input logic [1:0] ptr);
      logic [15:0] v;
      v = 16'h0000; // unused positions read zero
      case (ptr)
         VIEW_MONTH_DAY: begin
            v[HI_TEN_POS +: 1] = t.month_tens_digit;
            v[HI_ONE_POS +: 4] = t.month_ones_digit;
            v[LO_TEN_POS +: 2] = t.day_tens_digit;
            v[LO_ONE_POS +: 4] = t.day_ones_digit;
         end
         VIEW_WEEKDAY_VALUE_HOUR: begin
            v[HI_ONE_POS +: 3] = t.weekday_value;
            v[LO_TEN_POS +: 2] = t.hour_tens_digit;
            v[LO_ONE_POS +: 4] = t.hour_ones_digit;
         end
         VIEW_MIN_SEC: begin
            v[HI_TEN_POS +: 3] = t.minute_tens_digit;
            v[HI_ONE_POS +: 4] = t.minute_ones_digit;
            v[LO_TEN_POS +: 3] = t.second_tens_digit;
            v[LO_ONE_POS +: 4] = t.second_ones_digit;
         end
         default: begin // pointer 11 maps nothing
            v = 16'h0000;
         end
      endcase
      return v;
   endfunction : view_of

   assign alarm_value_window = view_of(alarm, alarm_view_pointer);
   assign clock_value_window = view_of(i_clock_time, clock_view_pointer);

   // spread byte strobes over the word
   generate
      for (genvar b = 0; b < 4; b++) begin : g_strb
         assign wmask[8*b +: 8] = {8{w_strb[b]}};
      end
   endgenerate

   // merge strobed data into the current view
   assign alarm_wr = (w_data[15:0] & wmask[15:0]) | (alarm_value_window & ~wmask[15:0]);

   // calendar views refuse writes while enable is low
   assign alarm_locked = !clock_write_enable &&
      (alarm_view_pointer == VIEW_MONTH_DAY || alarm_view_pointer == VIEW_WEEKDAY_VALUE_HOUR);

   // ************************************************
   // write address and data channels
   // ************************************************
   // address taken on handshake, released at the edge that raises the response
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else if (commit) begin
         aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1; // ready again once the response is gone
      end
   end

   // data channel taken independently of the address
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else if (commit) begin
         w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // response one cycle after both halves are held
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (commit) begin
         s_axi_bvalid <= 1'b1;
         // a refused alarm write still answers okay; the status bit reports it
         if (aw_addr == OFS_CTRL || aw_addr == OFS_ALARM || aw_addr == OFS_STATUS ||
             aw_addr == OFS_MASK || aw_addr == OFS_CLOCK) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR; // unmapped
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************
   // register writes
   // ************************************************
   // control register: enable and the two pointers only
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (commit && aw_addr == OFS_CTRL) begin
         ctrl[CTRL_WREN_POS] <= (w_data[CTRL_WREN_POS] & wmask[CTRL_WREN_POS]) |
            (ctrl[CTRL_WREN_POS] & ~wmask[CTRL_WREN_POS]);
         if (w_strb[1]) begin
            ctrl[CTRL_APTR_POS +: 2] <= w_data[CTRL_APTR_POS +: 2];
            ctrl[CTRL_CPTR_POS +: 2] <= w_data[CTRL_CPTR_POS +: 2];
         end
      end
   end

   // alarm storage: no reset, contents undefined until written
   always_ff @(posedge i_clk) begin
      if (commit && aw_addr == OFS_ALARM && !alarm_locked) begin
         case (alarm_view_pointer)
            VIEW_MONTH_DAY: begin
               alarm.month_tens_digit <= alarm_wr[HI_TEN_POS +: 1];
               alarm.month_ones_digit <= alarm_wr[HI_ONE_POS +: 4];
               alarm.day_tens_digit <= alarm_wr[LO_TEN_POS +: 2];
               alarm.day_ones_digit <= alarm_wr[LO_ONE_POS +: 4];
            end
            VIEW_WEEKDAY_VALUE_HOUR: begin
               alarm.weekday_value <= alarm_wr[HI_ONE_POS +: 3];
               alarm.hour_tens_digit <= alarm_wr[LO_TEN_POS +: 2];
               alarm.hour_ones_digit <= alarm_wr[LO_ONE_POS +: 4];
            end
            VIEW_MIN_SEC: begin
               alarm.minute_tens_digit <= alarm_wr[HI_TEN_POS +: 3];
               alarm.minute_ones_digit <= alarm_wr[HI_ONE_POS +: 4];
               alarm.second_tens_digit <= alarm_wr[LO_TEN_POS +: 3];
               alarm.second_ones_digit <= alarm_wr[LO_ONE_POS +: 4];
            end
            default: begin // unused bits and pointer 11 ignore writes
               alarm <= alarm;
            end
         endcase
      end
   end

   // track which views hold defined contents, so undefined bits never match
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         view_written <= 3'h0;
      end else if (commit && aw_addr == OFS_ALARM && !alarm_locked &&
                   alarm_view_pointer != 2'h3) begin
         view_written[alarm_view_pointer] <= 1'b1;
      end
   end

   // ************************************************
   // alarm compare and interrupt
   // ************************************************
   assign match_now = (&view_written) && (alarm == i_clock_time);

   // edge of the match, so a standing match is one event
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         match_d <= 1'b0;
      end else begin
         match_d <= match_now;
      end
   end

   // write-one-to-clear request, strobed bits only
   assign ev_clr = (commit && aw_addr == OFS_STATUS) ?
      (w_data[EV_COUNT-1:0] & wmask[EV_COUNT-1:0]) : EV_RESET;
   assign ev_set[EV_MATCH_POS] = match_now && !match_d;
   assign ev_set[EV_LOCKED_POS] = commit && aw_addr == OFS_ALARM && alarm_locked;

   // sticky status; a set in the clearing cycle wins
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ev_status <= EV_RESET;
      end else begin
         ev_status <= (ev_status & ~ev_clr) | ev_set;
      end
   end

   // mask register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ev_mask <= EV_RESET;
      end else if (commit && aw_addr == OFS_MASK) begin
         ev_mask <= (w_data[EV_COUNT-1:0] & wmask[EV_COUNT-1:0]) |
            (ev_mask & ~wmask[EV_COUNT-1:0]);
      end
   end

   // level interrupt, registered
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(ev_status & ev_mask);
      end
   end

   // ************************************************
   // read channel
   // ************************************************
   // address decode for reads
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;
      if (s_axi_araddr == OFS_CTRL) begin
         next_rdata = ctrl;
      end else if (s_axi_araddr == OFS_ALARM) begin
         next_rdata[15:0] = alarm_value_window;
      end else if (s_axi_araddr == OFS_CLOCK) begin
         next_rdata[15:0] = clock_value_window;
      end else if (s_axi_araddr == OFS_STATUS) begin
         next_rdata[EV_COUNT-1:0] = ev_status;
      end else if (s_axi_araddr == OFS_MASK) begin
         next_rdata[EV_COUNT-1:0] = ev_mask;
      end else begin
         next_rerr = 1'b1; // unmapped
      end
   end

   // one read at a time; data captured at the address handshake
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************
   // assertions
   // ************************************************
   view_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      alarm_view_pointer == VIEW_WEEKDAY_VALUE_HOUR && view_written[VIEW_WEEKDAY_VALUE_HOUR] |->
         alarm_value_window == {5'h00, alarm.weekday_value, 2'h0,
            alarm.hour_tens_digit, alarm.hour_ones_digit})
      else $error("weekday/hour view misformatted");

   write_lock_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      commit && aw_addr == OFS_ALARM && alarm_locked |=> $stable(alarm) &&
         ev_status[EV_LOCKED_POS])
      else $error("locked alarm view was written");

   month_tens_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      alarm_view_pointer == VIEW_MONTH_DAY && view_written[VIEW_MONTH_DAY] |->
         alarm_value_window[12] == alarm.month_tens_digit)
      else $error("month tens digit misplaced");

   month_ones_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      commit && aw_addr == OFS_ALARM && clock_write_enable && &w_strb[1:0] &&
      alarm_view_pointer == VIEW_MONTH_DAY |=>
         alarm.month_ones_digit == $past(w_data[11:8]))
      else $error("month ones digit not stored");

   minute_tens_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      commit && aw_addr == OFS_ALARM && w_strb[1] &&
      alarm_view_pointer == VIEW_MIN_SEC |=>
         alarm.minute_tens_digit == $past(w_data[14:12]))
      else $error("minute tens digit not stored");

   unused_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == OFS_ALARM |->
         s_axi_rdata[31:15] == 17'h00000 && s_axi_rdata[7] == 1'b0)
      else $error("unused alarm bits read nonzero");

   clock_view_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      clock_view_pointer == VIEW_MIN_SEC |->
         clock_value_window[3:0] == i_clock_time.second_ones_digit &&
         clock_value_window[14:12] == i_clock_time.minute_tens_digit)
      else $error("clock view misformatted");

   match_event_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      match_now && !match_d |=> ev_status[EV_MATCH_POS] ##1
         (o_irq || !$past(ev_mask[EV_MATCH_POS])))
      else $error("alarm match not recorded");

   write_resp_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      commit |=> s_axi_bvalid && !aw_held && !w_held)
      else $error("write response missing");
endmodule : rav_alarm_window

// File: tb.sv
// self-checking testbench for the alarm value window over AXI4-Lite
`timescale 1ns/1ps
module tb;
   import rav_pkg::*;
   // ****************************************
   // clock, reset and bus signals
   // ****************************************
   logic i_clk = 1'b0; // 20 MHz system clock
   logic i_rst_n = 1'b0; // synchronous, active low
   rav_time_type i_clock_time = '0; // running calendar time fed to the window
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, o_irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int n_mismatch = 0; // mismatches seen
   int checked = 0; // comparisons made
   // one table row: view pointer, word written, word read back
   typedef struct {logic [1:0] ptr; logic [31:0] wd; logic [31:0] exp;} rav_row_type;
   rav_row_type rows[5];
   logic [31:0] rd;
   logic [1:0] rsp;
   always #25 i_clk = ~i_clk;
   rav_alarm_window dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_clock_time(i_clock_time),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .o_irq(o_irq));
   // ****************************************
   // verdict and comparison helpers
   // ****************************************
   task close_out;
      $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   // a hung handshake ends the run as a mismatch
   task hang(input string msg);
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s timed out", $time, msg);
      close_out();
   endtask : hang
   // ****************************************
   // bus tasks; readies are sampled at the falling edge, since inputs and flops
   // only move at the rising edge this shows what the next rising edge takes
   // ****************************************
   task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_ok, w_ok, b_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      b_ok = 1'b0;
      n = 0;
      @(posedge i_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok) begin
         @(negedge i_clk);
         n++;
         if (n > 40) hang("write");
         if (awvalid && awready) aw_ok = 1'b1;
         if (wvalid && wready) w_ok = 1'b1;
         if (bvalid && bready) begin
            b_ok = 1'b1;
            r = bresp;
         end
         @(posedge i_clk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
         if (b_ok) bready <= 1'b0;
      end
   endtask : axi_wr
   task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic r_ok;
      r_ok = 1'b0;
      n = 0;
      @(posedge i_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_ok) begin
         @(negedge i_clk);
         n++;
         if (n > 40) hang("read");
         if (rvalid && rready) begin
            r_ok = 1'b1;
            d = rdata;
            r = rresp;
         end
         if (arvalid && arready) begin
            @(posedge i_clk);
            arvalid <= 1'b0;
         end else begin
            @(posedge i_clk);
         end
         if (r_ok) rready <= 1'b0;
      end
   endtask : axi_rd
   // write one word or read one word back; check the response, and the data on a read
   task wr_ok(input logic [7:0] a, input logic [31:0] d);
      axi_wr(a, d, rsp);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "write response");
   endtask : wr_ok
   task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      axi_rd(a, rd, rsp);
      chk(rd, exp, msg);
      chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "read response");
   endtask : rd_chk
   // interrupt level lags status by a cycle, so allow a short bounded wait
   task wait_irq(input logic lvl);
      int n;
      n = 0;
      while (o_irq !== lvl && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      chk({31'h0, o_irq}, {31'h0, lvl}, "irq level");
      // a used-up wait is already counted; end the run there
      if (o_irq !== lvl) begin
         close_out();
      end
   endtask : wait_irq
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rows[0] = '{VIEW_MIN_SEC, 32'hFFFF_8080, 32'h0000_0000};
      rows[1] = '{VIEW_MIN_SEC, 32'h0000_D9D9, 32'h0000_5959};
      rows[2] = '{VIEW_MONTH_DAY, 32'hFFFF_E0C0, 32'h0000_0000};
      rows[3] = '{VIEW_MONTH_DAY, 32'hFFFF_F2F9, 32'h0000_1239};
      rows[4] = '{VIEW_WEEKDAY_VALUE_HOUR, 32'h0000_FEE3, 32'h0000_0623};
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd_chk(OFS_CTRL, CTRL_RESET, "ctrl reset");
      rd_chk(OFS_STATUS, 32'h0, "status reset");
      rd_chk(OFS_MASK, 32'h0, "mask reset");
      chk({31'h0, o_irq}, 32'h0, "irq after reset");
      // table rows, enable set, each view written and read back
      foreach (rows[i]) begin
         wr_ok(OFS_CTRL, {22'h0, rows[i].ptr, 8'h01});
         wr_ok(OFS_ALARM, rows[i].wd);
         rd_chk(OFS_ALARM, rows[i].exp, "alarm view readback");
      end
      // clock window under its own pointer, same field layout
      i_clock_time <= '{1'h1, 4'h2, 2'h3, 4'h1, 3'h5, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h8};
      wr_ok(OFS_CTRL, {18'h0, VIEW_MONTH_DAY, 12'h001});
      rd_chk(OFS_CLOCK, 32'h0000_1231, "clock month day");
      wr_ok(OFS_CTRL, {18'h0, VIEW_WEEKDAY_VALUE_HOUR, 12'h001});
      rd_chk(OFS_CLOCK, 32'h0000_0523, "clock weekday hour");
      wr_ok(OFS_CTRL, {18'h0, VIEW_MIN_SEC, 12'h001});
      rd_chk(OFS_CLOCK, 32'h0000_5958, "clock minute second");
      // pointer 11 shows nothing and takes nothing; the views stay apart
      wr_ok(OFS_CTRL, 32'h0000_0301);
      wr_ok(OFS_ALARM, 32'hFFFF_FFFF);
      rd_chk(OFS_ALARM, 32'h0, "unused pointer");
      wr_ok(OFS_CTRL, 32'h0000_0201);
      rd_chk(OFS_ALARM, 32'h0000_1239, "month day kept");
      wr_ok(OFS_CTRL, 32'h0000_0101);
      rd_chk(OFS_ALARM, 32'h0000_0623, "weekday hour kept");
      wr_ok(OFS_CTRL, 32'h0000_0001);
      rd_chk(OFS_ALARM, 32'h0000_5959, "minute second kept");
      // enable low: calendar views refuse the write and flag it
      wr_ok(OFS_CTRL, 32'h0000_0200);
      wr_ok(OFS_ALARM, 32'h0000_0101);
      rd_chk(OFS_ALARM, 32'h0000_1239, "locked month day");
      wr_ok(OFS_CTRL, 32'h0000_0100);
      wr_ok(OFS_ALARM, 32'h0000_0101);
      rd_chk(OFS_ALARM, 32'h0000_0623, "locked weekday hour");
      rd_chk(OFS_STATUS, 32'h2, "refused write flag");
      // interrupt: masked off, then unmasked, then cleared by writing one
      wait_irq(1'b0);
      wr_ok(OFS_MASK, 32'h2);
      wait_irq(1'b1);
      wr_ok(OFS_STATUS, 32'h2);
      wait_irq(1'b0);
      rd_chk(OFS_STATUS, 32'h0, "status cleared");
      // running time reaches the stored alarm
      wr_ok(OFS_MASK, 32'h1);
      i_clock_time <= '{1'h1, 4'h2, 2'h3, 4'h9, 3'h6, 2'h2, 4'h3, 3'h5, 4'h9, 3'h5, 4'h9};
      wait_irq(1'b1);
      rd_chk(OFS_STATUS, 32'h1, "alarm match flag");
      wr_ok(OFS_STATUS, 32'h1);
      wait_irq(1'b0);
      // unmapped address answers with an error and reads zero
      axi_rd(8'h14, rd, rsp);
      chk(rd, 32'h0, "unmapped read data");
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped read response");
      axi_wr(8'h14, 32'hFFFF_FFFF, rsp);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped write response");
      // second reset in mid-run clears control, status and mask
      wr_ok(OFS_CTRL, 32'h0000_3200);
      wr_ok(OFS_ALARM, 32'h0000_0101);
      rd_chk(OFS_STATUS, 32'h2, "refused before reset");
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd_chk(OFS_CTRL, CTRL_RESET, "ctrl second reset");
      rd_chk(OFS_MASK, 32'h0, "mask second reset");
      rd_chk(OFS_STATUS, 32'h0, "status second reset");
      close_out();
   end
endmodule : tb
